/* include/inj_result_pkg.sv */
// package with constants for the injection result buffer
package inj_result_pkg;
	// ==========================================================
	// register map (one aligned word each)
	localparam logic [7:0]  CTRL_OFFS        = 8'h00;  // control: wait mode, hardware trigger enable
	localparam logic [7:0]  REQ_OFFS         = 8'h04;  // write: software injection request
	localparam logic [7:0]  STD_RESULT_OFFS  = 8'h08;  // standard_result_reg
	localparam logic [7:0]  INJ_RESULT_OFFS  = 8'h0c;  // injected_result_reg
	localparam logic [7:0]  STATUS_OFFS      = 8'h10;  // status
	// ==========================================================
	// field positions
	localparam int          CTRL_WAIT_BIT    = 0;      // wait-for-result-read mode
	localparam int          CTRL_HWTRIG_BIT  = 1;      // accept compare-channel trigger
	localparam int          REQ_INJ_BIT      = 0;      // software injection request
	localparam int          ST_DONE_BIT      = 0;      // injection_done_flag
	localparam int          ST_HOLD_BIT      = 1;      // holding register full
	localparam int          ST_HOLDINJ_BIT   = 2;      // held value is injected
	localparam int          ST_STALL_BIT     = 3;      // conversions suspended
	localparam int          ST_INJPEND_BIT   = 4;      // injection pending
	localparam int          ST_BUSY_BIT      = 5;      // conversion in flight
	localparam int          RES_W            = 10;     // result width
	localparam int          CHAN_W           = 5;      // channel number width
	localparam int          CHAN_POS         = 16;     // channel field in result words
	// ==========================================================
	// reset values
	localparam logic [1:0]  CTRL_RST         = 2'h0;
	localparam logic [31:0] RDATA_RST        = 32'h0000_0000;
endpackage : inj_result_pkg

/* hdl/adc_injection_result_buffer.sv */
// result handling and injection sequencing for the analog converter
//
// The address map and the APB slave port were chosen for this implementation.
module adc_injection_result_buffer
(
	input  wire logic        CORE_CLK,        // system clock, 50 MHz
	input  wire logic        ARST_N,          // asynchronous reset, active low
	input  wire logic        PSEL,            // apb select
	input  wire logic        PENABLE,         // apb access phase
	input  wire logic        PWRITE,          // apb direction
	input  wire logic [7:0]  PADDR,           // apb byte address
	input  wire logic [31:0] PWDATA,          // apb write data
	input  wire logic [3:0]  PSTRB,           // apb byte strobes
	output logic [31:0]      PRDATA,          // apb read data
	output logic             PREADY,          // apb ready
	output logic             PSLVERR,         // apb error on unmapped address
	input  wire logic        CMP_TRIG,        // injection_trigger_compare_channel event pulse
	input  wire logic [4:0]  INJ_CHANNEL,     // channel selected for injection
	input  wire logic [4:0]  STD_CHANNEL,     // channel of the standard sequence
	output logic             CONV_START,      // start pulse to the analog core
	output logic             CONV_IS_INJ,     // conversion being started is injected
	output logic [4:0]       CONV_CHANNEL,    // channel of the conversion being started
	input  wire logic        CONV_DONE,       // analog core finished, one cycle pulse
	input  wire logic [9:0]  CONV_DATA,       // result from the analog core
	input  wire logic        STD_REQ,         // standard sequence wants a conversion
	output logic             INJ_DONE_IRQ     // injection_done_irq request level
);
	// ==========================================================
	// bus decode
	logic        acc;                          // access phase, answered at once
	logic        wr;                           // write taken this edge
	logic        rd;                           // read taken this edge
	logic        mapped;                       // address hits a register
	assign acc    = PSEL & PENABLE;
	assign wr     = acc & PWRITE;
	assign rd     = acc & ~PWRITE;
	assign PREADY = 1'b1;                       // zero wait states
	always_comb
	begin
		unique case (PADDR)
			inj_result_pkg::CTRL_OFFS,
			inj_result_pkg::REQ_OFFS,
			inj_result_pkg::STD_RESULT_OFFS,
			inj_result_pkg::INJ_RESULT_OFFS,
			inj_result_pkg::STATUS_OFFS:   mapped = 1'b1;
			default:                      mapped = 1'b0;
		endcase
	end
	assign PSLVERR = acc & ~mapped;

	// decode helper used for every register hit except the mapped check behind PSLVERR
	function automatic logic hit(input logic [7:0] a, input logic [7:0] offs);
		hit = (a == offs);
	endfunction

	logic wr_ctrl;                              // control write, low byte enabled
	logic wr_req;                               // request write
	logic rd_inj;                               // injected result read
	assign wr_ctrl = wr & hit(PADDR, inj_result_pkg::CTRL_OFFS) & PSTRB[0];
	assign wr_req  = wr & hit(PADDR, inj_result_pkg::REQ_OFFS) & PSTRB[0];
	assign rd_inj  = rd & hit(PADDR, inj_result_pkg::INJ_RESULT_OFFS);

	// ==========================================================
	// control register
	logic [1:0] ctrl_q;                         // wait mode and trigger enable
	logic       wait_en;                        // wait-for-read mode
	logic       wait_rise;                      // wait mode turned back on
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			ctrl_q <= inj_result_pkg::CTRL_RST;
		else if (wr_ctrl)
			ctrl_q <= {PWDATA[inj_result_pkg::CTRL_HWTRIG_BIT], PWDATA[inj_result_pkg::CTRL_WAIT_BIT]};
	end
	assign wait_en   = ctrl_q[inj_result_pkg::CTRL_WAIT_BIT];
	assign wait_rise = wr_ctrl & ~wait_en & PWDATA[inj_result_pkg::CTRL_WAIT_BIT];

	// ==========================================================
	// injection request latch
	logic inj_pend_q;                           // injection waits for a start slot
	logic inj_req;                              // new request this cycle
	logic start_inj;                            // injection started this cycle
	logic start_std;                            // standard conversion started
	// hardware trigger only counts when enabled; injection requests are only taken in wait mode
	assign inj_req = wait_en & ((CMP_TRIG & ctrl_q[inj_result_pkg::CTRL_HWTRIG_BIT])
	                 | (wr_req & PWDATA[inj_result_pkg::REQ_INJ_BIT]));
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			inj_pend_q <= 1'b0;
		else if (inj_req)
			inj_pend_q <= 1'b1;                 // set wins over the start
		else if (start_inj)
			inj_pend_q <= 1'b0;
	end

	// ==========================================================
	// conversion sequencer
	typedef enum logic [2:0]
	{
		S_IDLE = 3'b001,                        // free to start
		S_CONV = 3'b010,                        // conversion in flight
		S_HALT = 3'b100                         // suspended on full holding register
	} seq_t;
	seq_t seq_q;                                // sequencer state
	logic cur_inj_q;                            // flight is injected
	logic hold_full_q;                          // holding register occupied
	logic hold_inj_q;                           // held value belongs to injection
	logic [9:0] hold_data_q;                    // held value
	logic [4:0] hold_chan_q;                    // held channel
	logic [4:0] conv_chan_q;                    // channel of flight
	logic inj_full_q;                           // injected result not yet read
	logic std_full_q;                           // standard result not yet read
	logic can_start;                            // no suspension
	logic halt_release;                         // wait mode turned back on by a control write
	logic done_inj_direct;                      // injected result goes to its register
	logic done_to_hold;                         // result parked in holding register

	// injection has priority; the running standard sequence resumes afterwards
	assign can_start = ~(wait_en & hold_full_q);
	assign start_inj = (seq_q == S_IDLE) & can_start & inj_pend_q;
	assign start_std = (seq_q == S_IDLE) & can_start & ~inj_pend_q & STD_REQ;
	assign halt_release = wait_rise;

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			seq_q <= S_IDLE;
		else
		begin
			unique case (seq_q)
				S_IDLE:
					if (start_inj | start_std)
						seq_q <= S_CONV;
					else if (wait_en & hold_full_q)
						seq_q <= S_HALT;
				S_CONV:
					if (CONV_DONE)
						seq_q <= S_IDLE;
				S_HALT:
					// leaves as soon as the hold drains, so it cannot lock up
					if (~hold_full_q | halt_release | ~wait_en)
						seq_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			cur_inj_q   <= 1'b0;
			conv_chan_q <= 5'h00;
		end
		else if (start_inj | start_std)
		begin
			cur_inj_q   <= start_inj;
			conv_chan_q <= start_inj ? INJ_CHANNEL : STD_CHANNEL;
		end
	end

	// start strobe and its qualifiers to the analog core
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			CONV_START   <= 1'b0;
			CONV_IS_INJ  <= 1'b0;
			CONV_CHANNEL <= 5'h00;
		end
		else
		begin
			CONV_START <= start_inj | start_std;
			if (start_inj | start_std)
			begin
				CONV_IS_INJ  <= start_inj;
				CONV_CHANNEL <= start_inj ? INJ_CHANNEL : STD_CHANNEL;
			end
		end
	end

	// ==========================================================
	// result registers and holding register
	logic [9:0] inj_data_q;                     // injected_result_reg value
	logic [4:0] inj_chan_q;                     // injected result channel
	logic [9:0] std_data_q;                     // standard_result_reg value
	logic [4:0] std_chan_q;                     // standard result channel
	logic       rd_std;                         // standard result read
	logic       move_hold;                      // holding register drains this cycle
	assign rd_std = rd & hit(PADDR, inj_result_pkg::STD_RESULT_OFFS);

	// in wait mode, an injected result whose register is occupied goes to the hold
	assign done_inj_direct = CONV_DONE & cur_inj_q & (~inj_full_q | rd_inj) & ~hold_full_q;
	assign done_to_hold    = CONV_DONE & wait_en & ~done_inj_direct
	                         & (cur_inj_q | std_full_q & ~rd_std);
	// held value moves into its register when that register is read
	assign move_hold = hold_full_q & ((hold_inj_q & rd_inj) | (~hold_inj_q & rd_std));

	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			hold_full_q <= 1'b0;
			hold_inj_q  <= 1'b0;
			hold_data_q <= 10'h000;
			hold_chan_q <= 5'h00;
		end
		else if (done_to_hold)
		begin
			hold_full_q <= 1'b1;
			hold_inj_q  <= cur_inj_q;
			hold_data_q <= CONV_DATA;
			hold_chan_q <= conv_chan_q;
		end
		// the sequencer has already left halt once wait mode went off, so the
		// re-enable alone must drop the parked value or the stall comes back
		else if (move_hold | halt_release)
			hold_full_q <= 1'b0;
	end

	// injected result register
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			inj_data_q <= 10'h000;
			inj_chan_q <= 5'h00;
			inj_full_q <= 1'b0;
		end
		else if (done_inj_direct)
		begin
			inj_data_q <= CONV_DATA;
			inj_chan_q <= conv_chan_q;
			inj_full_q <= 1'b1;
		end
		else if (move_hold & hold_inj_q)
		begin
			inj_data_q <= hold_data_q;
			inj_chan_q <= hold_chan_q;
			inj_full_q <= 1'b1;
		end
		else if (rd_inj)
			inj_full_q <= 1'b0;
	end

	// standard result register
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			std_data_q <= 10'h000;
			std_chan_q <= 5'h00;
			std_full_q <= 1'b0;
		end
		else if (CONV_DONE & ~cur_inj_q & ~done_to_hold)
		begin
			std_data_q <= CONV_DATA;            // overwrites when wait mode is off
			std_chan_q <= conv_chan_q;
			std_full_q <= 1'b1;
		end
		else if (move_hold & ~hold_inj_q)
		begin
			std_data_q <= hold_data_q;
			std_chan_q <= hold_chan_q;
			std_full_q <= 1'b1;
		end
		else if (rd_std)
			std_full_q <= 1'b0;
	end

	// ==========================================================
	// injection_done_flag: a fresh value sets it, reading the injected result clears it
	logic done_flag_q;                          // injection_done_flag
	logic done_set;                             // new injected value available
	assign done_set = done_inj_direct | (move_hold & hold_inj_q);
	always_ff @(posedge CORE_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			done_flag_q <= 1'b0;
		else if (done_set)
			done_flag_q <= 1'b1;                // set wins over the read
		else if (rd_inj)
			done_flag_q <= 1'b0;
	end
	assign INJ_DONE_IRQ = done_flag_q;

	// ==========================================================
	// read data mux, taken by the master at the access edge
	logic [31:0] rdata_d;                       // read mux
	always_comb
	begin
		rdata_d = inj_result_pkg::RDATA_RST;
		if (hit(PADDR, inj_result_pkg::CTRL_OFFS))
			rdata_d[1:0] = ctrl_q;
		else if (hit(PADDR, inj_result_pkg::STD_RESULT_OFFS))
		begin
			rdata_d[9:0]  = std_data_q;
			rdata_d[20:16] = std_chan_q;
		end
		else if (hit(PADDR, inj_result_pkg::INJ_RESULT_OFFS))
		begin
			rdata_d[9:0]  = inj_data_q;
			rdata_d[20:16] = inj_chan_q;
		end
		else if (hit(PADDR, inj_result_pkg::STATUS_OFFS))
		begin
			rdata_d[inj_result_pkg::ST_DONE_BIT]    = done_flag_q;
			rdata_d[inj_result_pkg::ST_HOLD_BIT]    = hold_full_q;
			rdata_d[inj_result_pkg::ST_HOLDINJ_BIT] = hold_full_q & hold_inj_q;
			rdata_d[inj_result_pkg::ST_STALL_BIT]   = (seq_q == S_HALT);
			rdata_d[inj_result_pkg::ST_INJPEND_BIT] = inj_pend_q;
			rdata_d[inj_result_pkg::ST_BUSY_BIT]    = (seq_q == S_CONV);
		end
	end
	// read data is combinational off registers so the zero-wait answer is valid in the access cycle
	assign PRDATA = rd ? rdata_d : inj_result_pkg::RDATA_RST;
endmodule // adc_injection_result_buffer

/* dv/adc_injection_result_buffer_props.sv */
// checker watching the ports of the injection result buffer
module adc_injection_result_buffer_props
(
	input wire logic        CORE_CLK,     // system clock
	input wire logic        ARST_N,       // async reset, active low
	input wire logic        PSEL,         // apb select
	input wire logic        PENABLE,      // apb access phase
	input wire logic        PWRITE,       // apb direction
	input wire logic [7:0]  PADDR,        // apb address
	input wire logic [31:0] PRDATA,       // apb read data
	input wire logic        PREADY,       // apb ready
	input wire logic        PSLVERR,      // apb error
	input wire logic [4:0]  INJ_CHANNEL,  // injection channel
	input wire logic        CONV_START,   // start pulse
	input wire logic        CONV_IS_INJ,  // start is injected
	input wire logic [4:0]  CONV_CHANNEL, // started channel
	input wire logic        CONV_DONE,    // core finished
	input wire logic        INJ_DONE_IRQ  // injection done request
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// helper terms
	logic rd_inj; // read access of the injected result
	logic mapped; // address hits a register
	assign rd_inj = PSEL && PENABLE && !PWRITE && PADDR == inj_result_pkg::INJ_RESULT_OFFS;
	assign mapped = PADDR <= inj_result_pkg::STATUS_OFFS && PADDR[1:0] == 2'h0;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	// ==========
	// properties
	property p_start_gap; CONV_START |=> !CONV_START [*3]; endproperty
	a_start_gap: assert property (p_start_gap) else $error("start too soon");
	property p_start_chan; CONV_START && CONV_IS_INJ |-> CONV_CHANNEL == $past(INJ_CHANNEL);
	endproperty
	a_start_chan: assert property (p_start_chan) else $error("wrong channel");
	property p_chan_held; CONV_START |=> $stable(CONV_CHANNEL) [*3]; endproperty
	a_chan_held: assert property (p_chan_held) else $error("channel not held");
	property p_irq_rise; $rose(INJ_DONE_IRQ) |->
		$past(CONV_DONE && CONV_IS_INJ) || $past(CONV_DONE && CONV_IS_INJ, 2); endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without result");
	property p_irq_fall; $fell(INJ_DONE_IRQ) |-> $past(rd_inj) || $past(rd_inj, 2); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped unread");
	property p_slverr; PSEL && PENABLE |-> PSLVERR == !mapped; endproperty
	a_slverr: assert property (p_slverr) else $error("bad error response");
	property p_rdata_idle; !(PSEL && PENABLE && !PWRITE) |-> PRDATA == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
	property p_pready; PSEL && PENABLE |-> PREADY; endproperty
	a_pready: assert property (p_pready) else $error("ready missing");
endmodule // adc_injection_result_buffer_props

bind adc_injection_result_buffer adc_injection_result_buffer_props i_props (
	.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.INJ_CHANNEL(INJ_CHANNEL), .CONV_START(CONV_START), .CONV_IS_INJ(CONV_IS_INJ),
	.CONV_CHANNEL(CONV_CHANNEL), .CONV_DONE(CONV_DONE), .INJ_DONE_IRQ(INJ_DONE_IRQ));

/* dv/adc_core_model.sv */
// behavioural analog core answering start pulses after a latency
module adc_core_model
#(
	parameter int LAT = 4 // cycles from start to done
)
(
	input wire logic        clk,    // system clock
	input wire logic        arst_n, // async reset, active low
	input wire logic        start,  // start pulse
	input wire logic        is_inj, // start is injected
	input wire logic [4:0]  chan,   // started channel
	output logic            done,   // one cycle done pulse
	output logic [9:0]      data    // result, garbage outside done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;  // latency countdown
	logic       busy_q; // conversion running
	logic       done_q; // done pulse
	logic [9:0] last_q; // last result
	// result encodes kind and channel so the bench can tell values apart
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			last_q <= 10'h0;
		end
		else
		begin
			done_q <= 1'b0;
			if (start)
			begin
				busy_q <= 1'b1;
				cnt_q <= 4'(LAT - 1);
				last_q <= {is_inj, 4'ha, chan};
			end
			else if (busy_q && cnt_q == 4'h0)
			begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end
			else if (busy_q)
				cnt_q <= cnt_q - 4'h1;
		end
	assign done = done_q;
	// inverted value outside the pulse so a stale sample never matches
	assign data = done_q ? last_q : ~last_q;
endmodule // adc_core_model

/* dv/adc_injection_result_buffer_bench.sv */
// self-checking bench for the injection result buffer
module adc_injection_result_buffer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// signals
	logic        clk, arst_n, psel, penable, pwrite, cmp_trig, std_req; // driven
	logic [7:0]  paddr;       // apb address
	logic [31:0] pwdata, rd;  // write data, last read
	logic [4:0]  inj_ch;      // injection channel
	logic        pready, pslverr, start, is_inj, done, irq, err; // observed
	logic [31:0] prdata;      // apb read data
	logic [4:0]  conv_ch;     // started channel
	logic [9:0]  cdata;       // core result
	int          n_fail = 0, num_checks = 0, n_start = 0, k;
	always #10 clk = ~clk;
	always @(posedge clk) if (start === 1'b1) n_start++;
	adc_injection_result_buffer i_adc_injection_result_buffer (
		.CORE_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CMP_TRIG(cmp_trig), .INJ_CHANNEL(inj_ch), .STD_CHANNEL(5'h09),
		.CONV_START(start), .CONV_IS_INJ(is_inj), .CONV_CHANNEL(conv_ch), .CONV_DONE(done),
		.CONV_DATA(cdata), .STD_REQ(std_req), .INJ_DONE_IRQ(irq));
	adc_core_model #(.LAT(4)) i_adc_core_model (.clk(clk), .arst_n(arst_n), .start(start),
		.is_inj(is_inj), .chan(conv_ch), .done(done), .data(cdata));
	// ==========
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, request held until ready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (n = 0; pready !== 1'b1 && n < 50; n++)
			@(posedge clk);
		chk(32'(pready), 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic inj(input logic [4:0] ch);
		inj_ch <= ch;
		apb(1'b1, inj_result_pkg::REQ_OFFS, 32'h1);
	endtask
	task automatic wait_irq(input logic v);
		int n;
		for (n = 0; irq !== v && n < 40; n++)
			@(posedge clk);
		chk(32'(irq), 32'(v));
	endtask
	// poll status until the holding register reports full
	task automatic hold_wait();
		for (int i = 0; i < 30; i++)
		begin
			apb(1'b0, inj_result_pkg::STATUS_OFFS, 32'h0);
			if (rd[inj_result_pkg::ST_HOLD_BIT] === 1'b1)
				break;
		end
	endtask
	function automatic logic [31:0] word(input logic [4:0] ch);
		return {11'h0, ch, 6'h0, 1'b1, 4'ha, ch};
	endfunction
	// ==========
	// scenarios
	task automatic t_reset();
		rd_chk(inj_result_pkg::CTRL_OFFS, 32'h0);
		rd_chk(inj_result_pkg::STATUS_OFFS, 32'h0);
		rd_chk(8'h40, 32'h0);
		chk(32'(err), 32'h1);
		$display("test reset done");
	endtask
	task automatic t_nowait();
		k = n_start;
		inj(5'h02);
		repeat (10) @(posedge clk);
		chk(n_start, k);
		$display("test nowait done");
	endtask
	task automatic t_single();
		apb(1'b1, inj_result_pkg::CTRL_OFFS, 32'h1);
		inj(5'h03);
		wait_irq(1'b1);
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h03));
		wait_irq(1'b0);
		rd_chk(inj_result_pkg::STATUS_OFFS, 32'h0);
		$display("test single done");
	endtask
	task automatic t_double();
		inj(5'h04);
		wait_irq(1'b1);
		inj(5'h05);
		hold_wait();
		chk(32'(rd[2:0]), 32'h7);
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h04));
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h1);
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h05));
		wait_irq(1'b0);
		inj(5'h06);
		wait_irq(1'b1);
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h06));
		$display("test double done");
	endtask
	task automatic t_release();
		inj(5'h07);
		wait_irq(1'b1);
		inj(5'h08);
		hold_wait();
		apb(1'b1, inj_result_pkg::CTRL_OFFS, 32'h0);
		apb(1'b1, inj_result_pkg::CTRL_OFFS, 32'h1);
		rd_chk(inj_result_pkg::STATUS_OFFS, 32'h1);
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h07));
		wait_irq(1'b0);
		inj(5'h11);
		wait_irq(1'b1);
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h11));
		$display("test release done");
	endtask
	task automatic t_hw();
		k = n_start;
		inj_ch <= 5'h0a;
		@(posedge clk);
		cmp_trig <= 1'b1;
		@(posedge clk);
		cmp_trig <= 1'b0;
		repeat (10) @(posedge clk);
		chk(n_start, k);
		apb(1'b1, inj_result_pkg::CTRL_OFFS, 32'h3);
		cmp_trig <= 1'b1;
		@(posedge clk);
		cmp_trig <= 1'b0;
		wait_irq(1'b1);
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h0a));
		$display("test hw trigger done");
	endtask
	// one standard conversion, then an injection on top of the running sequence
	task automatic t_std();
		std_req <= 1'b1;
		@(posedge clk);
		std_req <= 1'b0;
		inj(5'h0c);
		wait_irq(1'b1);
		rd_chk(inj_result_pkg::STD_RESULT_OFFS, {11'h0, 5'h09, 7'h0, 4'ha, 5'h09});
		rd_chk(inj_result_pkg::INJ_RESULT_OFFS, word(5'h0c));
		$display("test standard done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ==========
	// main sequence and watchdog
	initial
	begin
		clk = 1'b0;
		{arst_n, psel, penable, pwrite, cmp_trig, std_req} = 6'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		inj_ch = 5'h0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_nowait();
		t_single();
		t_double();
		t_release();
		t_hw();
		t_std();
		print_verdict();
	end
	initial
	begin
		#200000;
		n_fail++;
		print_verdict();
	end
endmodule // adc_injection_result_buffer_bench
